// file: include/nmpe_defs.svh
// constants for the multi-plane program and erase sequencer
`ifndef NMPE_DEFS_SVH
`define NMPE_DEFS_SVH

`define NMPE_CLK_MHZ       50
`define NMPE_CYC(ns)       ((((ns) * `NMPE_CLK_MHZ) + 999) / 1000)

// busy times in ns
`define NMPE_DBSY_NS       500
`define NMPE_CBSY_NS       2000
`define NMPE_PROG_NS       300000
`define NMPE_BERS_NS       1000000
`define NMPE_DBSY_CYC      `NMPE_CYC(`NMPE_DBSY_NS)
`define NMPE_CBSY_CYC      `NMPE_CYC(`NMPE_CBSY_NS)
`define NMPE_PROG_CYC      `NMPE_CYC(`NMPE_PROG_NS)
`define NMPE_BERS_CYC      `NMPE_CYC(`NMPE_BERS_NS)
`define NMPE_TW            24

// opcodes
`define NMPE_OP_PROG_SETUP 8'h80
`define NMPE_OP_PROG_MP    8'h11
`define NMPE_OP_PROG_END   8'h10
`define NMPE_OP_PROG_CACHE 8'h15
`define NMPE_OP_CHANGE     8'h85
`define NMPE_OP_ERASE_SET  8'h60
`define NMPE_OP_ERASE_END  8'hd0
`define NMPE_OP_ERASE_MP   8'hd1
`define NMPE_OP_STATUS     8'h70
`define NMPE_OP_STATUS_LUN 8'h78

// address cycles
`define NMPE_PROG_ADDR_CYC 3'h5
`define NMPE_ERASE_ADDR_CYC 3'h3
`define NMPE_PLANE_BIT     7

// register map
`define NMPE_REG_CTRL      12'h000
`define NMPE_REG_STATUS    12'h004
`define NMPE_REG_REJECT    12'h008
`define NMPE_CTRL_RESET    2'h0

// status word fields
`define NMPE_ST_READY      0
`define NMPE_ST_ARRAY_READY_FLAG       1
`define NMPE_ST_CACHE      2
`define NMPE_ST_PROGQ      4
`define NMPE_ST_ERASEQ     6
`define NMPE_ST_FAIL       8
`define NMPE_ST_PRIOR_CACHE_OP_ERROR_FLAG      10

`endif

// file: include/nmpe_pkg.sv
// types of the multi-plane program and erase sequencer
package nmpe_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PADDR,
    ST_PDATA,
    ST_CHG,
    ST_EADDR,
    ST_WAIT
  } nmpe_state_e;

  typedef enum logic [1:0] {
    FK_DUMMY,
    FK_PROG,
    FK_ERASE,
    FK_CACHE
  } nmpe_kind_e;

  typedef struct packed {
    logic       cmd_we;
    logic       addr_we;
    logic       data_we;
    logic [7:0] io;
  } nmpe_host_s;

endpackage

// file: rtl/nmpe_seq.sv
// multi-plane page program and block erase command sequencer
//
// Overview of operation
// - on 11h both ready flags drop and the pin shows busy.
// - 80h clears all cache registers unless a queueing program preceded it.
// - each queueing program adds its plane to the pending program set.
// - queueing program accepted only while ready flag is one.
// - 85h during data entry redirects the following data.
// - 10h or 15h closes the sequence and transfers all queued planes.
// - 10h programs all queued planes for page program time.
// - 15h waits for array, copies caches, programs in background past cache busy.
// - erase confirm holds both flags low for block erase time.
// - erase commands accepted only with both ready flags high.
// - 60h, three rows, D1h queues a block; dummy busy follows.
// - D1h adds plane to erase set; D0h adds its own, erases all.
// - D0h without preceding D1h erases exactly one block.
`timescale 1ns/100ps
`include "nmpe_defs.svh"

module nmpe_seq
#(
  parameter int PROG_CYC = `NMPE_PROG_CYC,
  parameter int BERS_CYC = `NMPE_BERS_CYC
)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // host command, address and data cycles
  input  wire nmpe_pkg::nmpe_host_s host,
  // ready/busy pin, open drain
  output logic                      rb_o,
  output logic                      rb_oe,
  // flags
  output logic                      ready_flag,
  output logic                      array_ready_flag,
  output logic [1:0]                op_error_flag,
  output logic [1:0]                prior_cache_op_error_flag,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr
);

  // ****************************************************************
  // state
  // ****************************************************************
  nmpe_pkg::nmpe_state_e state_r, state_nxt;
  nmpe_pkg::nmpe_kind_e  kind_r, kind_nxt;
  logic [2:0]            cnt_r, cnt_nxt;
  logic [15:0]           col_r, col_nxt;
  logic                  plane_r, plane_nxt;
  logic [1:0]            cache_r, cache_nxt;
  logic [1:0]            progq_r, progq_nxt;
  logic [1:0]            eraseq_r, eraseq_nxt;
  logic [1:0]            arrq_r, arrq_nxt;
  logic [1:0]            fail_r, fail_nxt;
  logic [1:0]            prior_cache_op_error_flag_r, prior_cache_op_error_flag_nxt;
  logic                  mp_prev_r, mp_prev_nxt;
  logic                  cmode_r, cmode_nxt;
  logic                  rej_ev;
  logic                  front_start, front_busy, front_done;
  logic [`NMPE_TW-1:0]   front_val;
  logic                  arr_start, arr_busy, arr_done;
  logic [1:0]            inject_r;
  logic                  reject_r;
  logic                  in_data;
  logic [1:0]            pmask;

  assign in_data          = (state_r == nmpe_pkg::ST_PDATA) ||
                            (state_r == nmpe_pkg::ST_CHG);
  assign pmask            = plane_r ? 2'b10 : 2'b01;
  assign ready_flag       = !front_busy && (state_r != nmpe_pkg::ST_WAIT);
  assign array_ready_flag = ready_flag && !arr_busy;
  // pin pulled low while busy
  assign rb_o             = 1'b0;
  assign rb_oe            = !ready_flag;
  assign op_error_flag    = fail_r;
  assign prior_cache_op_error_flag = prior_cache_op_error_flag_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // busy timers
  // ****************************************************************
  nmpe_timer u_front
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (front_start),
    .load_val (front_val),
    .busy     (front_busy),
    .done     (front_done)
  );

  nmpe_timer u_array
  (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (arr_start),
    .load_val (PROG_CYC[`NMPE_TW-1:0]),
    .busy     (arr_busy),
    .done     (arr_done)
  );

  // ****************************************************************
  // command sequencing
  // ****************************************************************
  always_comb
  begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    cnt_nxt     = cnt_r;
    col_nxt     = col_r;
    plane_nxt   = plane_r;
    cache_nxt   = cache_r;
    progq_nxt   = progq_r;
    eraseq_nxt  = eraseq_r;
    arrq_nxt    = arrq_r;
    fail_nxt    = fail_r;
    prior_cache_op_error_flag_nxt   = prior_cache_op_error_flag_r;
    mp_prev_nxt = mp_prev_r;
    cmode_nxt   = cmode_r;
    rej_ev      = 1'b0;
    front_start = 1'b0;
    front_val   = `NMPE_TW'(`NMPE_DBSY_CYC);
    arr_start   = 1'b0;
    if (front_done)
    begin
      case (kind_r)
        nmpe_pkg::FK_PROG:
        begin
          fail_nxt    = inject_r & progq_r;
          progq_nxt   = 2'b00;
          mp_prev_nxt = 1'b0;
        end
        nmpe_pkg::FK_ERASE:
        begin
          fail_nxt    = inject_r & eraseq_r;
          eraseq_nxt  = 2'b00;
        end
        nmpe_pkg::FK_CACHE:
        begin
          progq_nxt   = 2'b00;
          mp_prev_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (arr_done)
      fail_nxt = inject_r & arrq_r;
    if ((state_r == nmpe_pkg::ST_WAIT) && !arr_busy)
    begin
      front_start = 1'b1;
      state_nxt   = nmpe_pkg::ST_IDLE;
      if (cmode_r)
      begin
        arr_start = 1'b1;
        arrq_nxt  = progq_r;
        prior_cache_op_error_flag_nxt = fail_r;
        cache_nxt = 2'b00;
        kind_nxt  = nmpe_pkg::FK_CACHE;
        front_val = `NMPE_TW'(`NMPE_CBSY_CYC);
      end
      else
      begin
        kind_nxt  = nmpe_pkg::FK_PROG;
        front_val = PROG_CYC[`NMPE_TW-1:0];
      end
    end
    if (host.cmd_we)
    begin
      if ((host.io == `NMPE_OP_STATUS) || (host.io == `NMPE_OP_STATUS_LUN))
        rej_ev = 1'b0;
      else if (!ready_flag)
        rej_ev = 1'b1;
      else
      begin
        case (host.io)
          `NMPE_OP_PROG_SETUP:
          begin
            if (!mp_prev_r)
              cache_nxt = 2'b00;
            state_nxt = nmpe_pkg::ST_PADDR;
            cnt_nxt   = 3'h0;
          end
          `NMPE_OP_ERASE_SET:
          begin
            if (array_ready_flag)
            begin
              state_nxt = nmpe_pkg::ST_EADDR;
              cnt_nxt   = 3'h0;
            end
            else
              rej_ev = 1'b1;
          end
          `NMPE_OP_CHANGE:
          begin
            if (in_data)
            begin
              state_nxt = nmpe_pkg::ST_CHG;
              cnt_nxt   = 3'h0;
            end
            else
              rej_ev = 1'b1;
          end
          `NMPE_OP_PROG_MP:
          begin
            if (in_data)
            begin
              progq_nxt   = progq_r | pmask;
              mp_prev_nxt = 1'b1;
              front_start = 1'b1;
              kind_nxt    = nmpe_pkg::FK_DUMMY;
              state_nxt   = nmpe_pkg::ST_IDLE;
            end
            else
              rej_ev = 1'b1;
          end
          `NMPE_OP_PROG_END,
          `NMPE_OP_PROG_CACHE:
          begin
            if (in_data)
            begin
              progq_nxt = progq_r | pmask;
              cmode_nxt = (host.io == `NMPE_OP_PROG_CACHE);
              state_nxt = nmpe_pkg::ST_WAIT;
            end
            else
              rej_ev = 1'b1;
          end
          `NMPE_OP_ERASE_MP,
          `NMPE_OP_ERASE_END:
          begin
            if ((state_r == nmpe_pkg::ST_EADDR) &&
                (cnt_r == `NMPE_ERASE_ADDR_CYC))
            begin
              eraseq_nxt  = eraseq_r | pmask;
              front_start = 1'b1;
              state_nxt   = nmpe_pkg::ST_IDLE;
              if (host.io == `NMPE_OP_ERASE_END)
              begin
                kind_nxt  = nmpe_pkg::FK_ERASE;
                front_val = BERS_CYC[`NMPE_TW-1:0];
              end
              else
                kind_nxt = nmpe_pkg::FK_DUMMY;
            end
            else
              rej_ev = 1'b1;
          end
          default:
            rej_ev = 1'b1;
        endcase
      end
    end
    else if (host.addr_we)
    begin
      case (state_r)
        nmpe_pkg::ST_PADDR,
        nmpe_pkg::ST_CHG:
        begin
          case (cnt_r)
            3'h0:    col_nxt[7:0]  = host.io;
            3'h1:    col_nxt[15:8] = host.io;
            3'h2:    plane_nxt     = host.io[`NMPE_PLANE_BIT];
            default: ;
          endcase
          if (cnt_r != `NMPE_PROG_ADDR_CYC)
            cnt_nxt = cnt_r + 3'h1;
          if ((state_r == nmpe_pkg::ST_PADDR) &&
              (cnt_r == `NMPE_PROG_ADDR_CYC - 3'h1))
            state_nxt = nmpe_pkg::ST_PDATA;
        end
        nmpe_pkg::ST_EADDR:
        begin
          // page bits ignored, block picks plane
          if (cnt_r == 3'h0)
            plane_nxt = host.io[`NMPE_PLANE_BIT];
          if (cnt_r != `NMPE_ERASE_ADDR_CYC)
            cnt_nxt = cnt_r + 3'h1;
          else
            rej_ev = 1'b1;
        end
        default:
          rej_ev = 1'b1;
      endcase
    end
    else if (host.data_we)
    begin
      if (in_data)
      begin
        cache_nxt = cache_r | pmask;
        col_nxt   = col_r + 16'h0001;
        state_nxt = nmpe_pkg::ST_PDATA;
      end
      else
        rej_ev = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r   <= nmpe_pkg::ST_IDLE;
      kind_r    <= nmpe_pkg::FK_DUMMY;
      cnt_r     <= 3'h0;
      col_r     <= 16'h0000;
      plane_r   <= 1'b0;
      cache_r   <= 2'h0;
      progq_r   <= 2'h0;
      eraseq_r  <= 2'h0;
      arrq_r    <= 2'h0;
      fail_r    <= 2'h0;
      prior_cache_op_error_flag_r   <= 2'h0;
      mp_prev_r <= 1'b0;
      cmode_r   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      kind_r    <= kind_nxt;
      cnt_r     <= cnt_nxt;
      col_r     <= col_nxt;
      plane_r   <= plane_nxt;
      cache_r   <= cache_nxt;
      progq_r   <= progq_nxt;
      eraseq_r  <= eraseq_nxt;
      arrq_r    <= arrq_nxt;
      fail_r    <= fail_nxt;
      prior_cache_op_error_flag_r   <= prior_cache_op_error_flag_nxt;
      mp_prev_r <= mp_prev_nxt;
      cmode_r   <= cmode_nxt;
    end
  end

  // ****************************************************************
  // apb registers
  // ****************************************************************
  logic        wr_acc, rd_setup, mapped;
  logic [1:0]  inject_nxt;
  logic        reject_nxt;
  logic [31:0] prdata_nxt;
  logic [31:0] status_w;

  assign mapped   = (paddr == `NMPE_REG_CTRL) ||
                    (paddr == `NMPE_REG_STATUS) ||
                    (paddr == `NMPE_REG_REJECT);
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb
  begin
    status_w = 32'h0000_0000;
    status_w[`NMPE_ST_READY]          = ready_flag;
    status_w[`NMPE_ST_ARRAY_READY_FLAG]           = array_ready_flag;
    status_w[`NMPE_ST_CACHE  +: 2]    = cache_r;
    status_w[`NMPE_ST_PROGQ  +: 2]    = progq_r;
    status_w[`NMPE_ST_ERASEQ +: 2]    = eraseq_r;
    status_w[`NMPE_ST_FAIL   +: 2]    = fail_r;
    status_w[`NMPE_ST_PRIOR_CACHE_OP_ERROR_FLAG  +: 2]    = prior_cache_op_error_flag_r;
    inject_nxt = inject_r;
    reject_nxt = reject_r;
    prdata_nxt = prdata;
    if (wr_acc && (paddr == `NMPE_REG_CTRL))
      inject_nxt = pwdata[1:0];
    // write one clears, a new event wins
    if (wr_acc && (paddr == `NMPE_REG_REJECT) && pwdata[0])
      reject_nxt = 1'b0;
    if (rej_ev)
      reject_nxt = 1'b1;
    if (rd_setup)
    begin
      case (paddr)
        `NMPE_REG_CTRL:   prdata_nxt = {30'h0, inject_r};
        `NMPE_REG_STATUS: prdata_nxt = status_w;
        `NMPE_REG_REJECT: prdata_nxt = {31'h0, reject_r};
        default:          prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      inject_r <= `NMPE_CTRL_RESET;
      reject_r <= 1'b0;
      prdata   <= 32'h0000_0000;
    end
    else
    begin
      inject_r <= inject_nxt;
      reject_r <= reject_nxt;
      prdata   <= prdata_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic acc_mp, acc_erase_end, acc_erase_mp, acc_setup;
  assign acc_mp        = host.cmd_we && ready_flag && in_data &&
                         (host.io == `NMPE_OP_PROG_MP);
  assign acc_erase_end = host.cmd_we && ready_flag &&
                         (state_r == nmpe_pkg::ST_EADDR) &&
                         (cnt_r == `NMPE_ERASE_ADDR_CYC) &&
                         (host.io == `NMPE_OP_ERASE_END);
  assign acc_erase_mp  = host.cmd_we && ready_flag &&
                         (state_r == nmpe_pkg::ST_EADDR) &&
                         (cnt_r == `NMPE_ERASE_ADDR_CYC) &&
                         (host.io == `NMPE_OP_ERASE_MP);
  assign acc_setup     = host.cmd_we && ready_flag &&
                         (host.io == `NMPE_OP_PROG_SETUP);

  chk_mp_dummy_busy: assert property (
    acc_mp |=> (!ready_flag && !array_ready_flag && rb_oe) [*8])
    else $error("queueing program did not go busy");
  chk_mp_queue_add: assert property (
    acc_mp |=> (progq_r == ($past(progq_r) | $past(pmask))) && mp_prev_r)
    else $error("plane not added to program queue");
  chk_mp_needs_ready: assert property (
    (host.cmd_we && !ready_flag && !front_done &&
     (host.io == `NMPE_OP_PROG_MP))
      |=> $stable(progq_r) && reject_r)
    else $error("queueing program taken while busy");
  chk_cache_clear: assert property (
    (acc_setup && !mp_prev_r) |=> (cache_r == 2'b00))
    else $error("cache not cleared by setup");
  chk_cache_keep: assert property (
    (acc_setup && mp_prev_r && !front_done) |=> $stable(cache_r))
    else $error("queued cache lost on setup");
  chk_col_change: assert property (
    (host.addr_we && (state_r == nmpe_pkg::ST_CHG) && (cnt_r == 3'h0))
      |=> (col_r[7:0] == $past(host.io)))
    else $error("column change not applied");
  chk_erase_accept: assert property (
    (host.cmd_we && !array_ready_flag && (host.io == `NMPE_OP_ERASE_SET))
      |=> (state_r != nmpe_pkg::ST_EADDR))
    else $error("erase setup taken while not ready");
  chk_erase_single: assert property (
    (acc_erase_end && (eraseq_r == 2'b00)) |=> $onehot(eraseq_r))
    else $error("single erase did not queue one block");
  chk_erase_busy: assert property (
    acc_erase_end |=> (!ready_flag && (kind_r == nmpe_pkg::FK_ERASE)) [*8])
    else $error("erase confirm not busy");
  chk_emp_dbsy: assert property (
    acc_erase_mp |=> !ready_flag ##[1:300] ready_flag && (eraseq_r != 2'b00))
    else $error("erase queueing dummy busy wrong");
  chk_cache_wait: assert property (
    ((state_r == nmpe_pkg::ST_WAIT) && arr_busy)
      |-> !front_start && !arr_start ##1 !ready_flag)
    else $error("cache copy started before array idle");
  chk_busy_end: assert property (
    (front_done && (kind_r != nmpe_pkg::FK_DUMMY))
      |=> ready_flag && ((kind_r == nmpe_pkg::FK_ERASE) ?
          (eraseq_r == 2'b00) : (progq_r == 2'b00)))
    else $error("queue not emptied at busy end");

endmodule // nmpe_seq

// file: rtl/nmpe_timer.sv
// busy period down-counter
`timescale 1ns/100ps
`include "nmpe_defs.svh"

module nmpe_timer
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // control
  input  wire logic                   start,
  input  wire logic [`NMPE_TW-1:0]    load_val,
  // state
  output logic                        busy,
  output logic                        done
);

  logic [`NMPE_TW-1:0] cnt_r;
  logic [`NMPE_TW-1:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (start)
      cnt_nxt = load_val;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign busy = (cnt_r != '0);
  // last busy cycle
  assign done = (cnt_r == `NMPE_TW'h1);

endmodule // nmpe_timer

// file: tb/nmpe_host_model.sv
// host flash controller model issuing command sequences
`timescale 1ns/100ps

module nmpe_host_model
(
  // clock
  input  wire logic            sys_clk,
  // device state
  input  wire logic            ready_flag,
  // host cycles
  output nmpe_pkg::nmpe_host_s host
);
  initial host = '0;

  // one strobe cycle; io is inverted once released
  task automatic cyc(input logic [2:0] k, input logic [7:0] v);
    @(posedge sys_clk);
    host <= {k, v};
    @(posedge sys_clk);
    host <= {3'h0, ~v};
  endtask

  // program entry, optional column change and close
  task automatic prog(input logic [7:0] cl, input logic pl, input logic chg);
    cyc(3'h4, 8'h80);
    for (int i = 0; i < 5; i++)
      cyc(3'h2, (i == 2) ? {pl, 7'h05} : 8'h00);
    cyc(3'h1, 8'ha5);
    if (chg)
    begin
      cyc(3'h4, 8'h85);
      cyc(3'h2, 8'h10);
      cyc(3'h2, 8'h00);
      cyc(3'h1, 8'h5a);
    end
    if (cl != 8'h00)
      cyc(3'h4, cl);
  endtask

  // erase set, three row cycles, confirm
  task automatic erase(input logic [7:0] cl, input logic pl);
    cyc(3'h4, 8'h60);
    cyc(3'h2, {pl, 7'h3f});
    cyc(3'h2, 8'h12);
    cyc(3'h2, 8'h00);
    cyc(3'h4, cl);
  endtask

  // poll with unit status until ready
  task automatic poll(input int lim);
    int n;
    n = 0;
    #1;
    while (ready_flag !== 1'b1 && n < lim)
    begin
      cyc(3'h4, 8'h78);
      n++;
    end
  endtask
endmodule // nmpe_host_model

// file: tb/test_nand_multiplane_program_erase.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/100ps
`include "nmpe_defs.svh"

module test_nand_multiplane_program_erase;
  logic                 sys_clk, rst, psel, penable, pwrite, err;
  logic                 rb_o, rb_oe, ready_flag, array_ready_flag, pready;
  logic                 pslverr;
  logic [1:0]           op_error_flag, prior_cache_op_error_flag;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  nmpe_pkg::nmpe_host_s host;
  int                   fails, total_checks, n;

  nmpe_seq #(.PROG_CYC(150), .BERS_CYC(60)) uut (.sys_clk(sys_clk),
    .rst(rst), .host(host), .rb_o(rb_o), .rb_oe(rb_oe),
    .ready_flag(ready_flag), .array_ready_flag(array_ready_flag),
    .op_error_flag(op_error_flag),
    .prior_cache_op_error_flag(prior_cache_op_error_flag),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  nmpe_host_model host_m (.sys_clk(sys_clk), .ready_flag(ready_flag),
    .host(host));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts cycles with the ready flag low
  task automatic busy(output int c);
    c = 0;
    #1;
    while (ready_flag !== 1'b1 && c < 5000)
    begin
      c++;
      @(posedge sys_clk);
      #1;
    end
    check("busy limit", 1, c < 5000);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    check("ready", 1, ready_flag);
    check("array ready", 1, array_ready_flag);
    check("pin busy", 0, rb_oe);
    check("pin level", 0, rb_o);
    host_m.cyc(3'h4, 8'h70);
    apb(0, `NMPE_REG_STATUS, 0);
    check("status", 32'h3, rd);
    apb(0, `NMPE_REG_REJECT, 0);
    check("reject", 0, rd);
    apb(0, 12'h00c, 0);
    check("unmapped", 1, err);
    $display("test reset done");
  endtask

  task automatic t_prog;
    apb(1, `NMPE_REG_CTRL, 32'h2);
    host_m.prog(8'h11, 1'b0, 1'b1);
    #1;
    check("ready low", 0, ready_flag);
    check("array low", 0, array_ready_flag);
    check("pin busy", 1, rb_oe);
    busy(n);
    check("dummy busy", 25, n);
    apb(0, `NMPE_REG_STATUS, 0);
    check("queue", 4'b0101, rd[5:2]);
    host_m.prog(8'h00, 1'b1, 1'b0);
    apb(0, `NMPE_REG_STATUS, 0);
    check("caches kept", 2'b11, rd[3:2]);
    host_m.cyc(3'h4, 8'h10);
    busy(n);
    check("prog busy", 151, n);
    apb(0, `NMPE_REG_STATUS, 0);
    check("fail", 2'b10, op_error_flag);
    check("queue empty", 0, rd[5:4]);
    apb(0, `NMPE_REG_REJECT, 0);
    check("change taken", 0, rd[0]);
    $display("test program done");
  endtask

  task automatic t_erase;
    apb(1, `NMPE_REG_CTRL, 32'h3);
    host_m.erase(8'hd0, 1'b1);
    busy(n);
    check("erase busy", 60, n);
    apb(0, `NMPE_REG_STATUS, 0);
    check("one block", 2'b10, op_error_flag);
    host_m.erase(8'hd1, 1'b0);
    #1;
    check("queue busy", 1, rb_oe);
    host_m.cyc(3'h4, 8'h11);
    apb(0, `NMPE_REG_STATUS, 0);
    check("erase queue", 2'b01, rd[7:6]);
    host_m.poll(500);
    host_m.erase(8'hd0, 1'b1);
    host_m.poll(500);
    check("ready after erase", 1, ready_flag);
    apb(0, `NMPE_REG_STATUS, 0);
    check("all erased", 2'b11, op_error_flag);
    check("erase queue empty", 0, rd[7:6]);
    apb(0, `NMPE_REG_REJECT, 0);
    check("busy refusal", 1, rd[0]);
    apb(1, `NMPE_REG_REJECT, 32'h1);
    apb(0, `NMPE_REG_REJECT, 0);
    check("refusal cleared", 0, rd[0]);
    $display("test erase done");
  endtask

  task automatic t_cache;
    apb(1, `NMPE_REG_CTRL, 32'h1);
    host_m.prog(8'h00, 1'b0, 1'b0);
    apb(0, `NMPE_REG_STATUS, 0);
    check("caches cleared", 2'b01, rd[3:2]);
    host_m.cyc(3'h4, 8'h15);
    busy(n);
    check("cache busy", 101, n);
    check("array busy", 0, array_ready_flag);
    check("prior fail", 2'b11, prior_cache_op_error_flag);
    host_m.erase(8'hd0, 1'b0);
    apb(0, `NMPE_REG_REJECT, 0);
    check("erase refused", 1, rd[0]);
    repeat (300)
      if (array_ready_flag !== 1'b1)
        @(posedge sys_clk);
    @(posedge sys_clk);
    #1;
    check("array done", 1, array_ready_flag);
    check("cache fail", 2'b01, op_error_flag);
    host_m.prog(8'h15, 1'b1, 1'b0);
    busy(n);
    check("prior fail again", 2'b01, prior_cache_op_error_flag);
    host_m.prog(8'h10, 1'b0, 1'b0);
    busy(n);
    check("program waits array", 1, n > 151);
    check("final fail", 2'b01, op_error_flag);
    $display("test cache done");
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    #1000000;
    fails++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_prog();
    t_erase();
    t_cache();
    finish_test();
  end
endmodule // test_nand_multiplane_program_erase
